// ---- src/scpm_pkg.sv ----
// Package with constants and types of the system clock and power mode controller.
package scpm_pkg;
   localparam logic [31:0] MODE_REG_OFS   = 32'h0000_0000;
   localparam logic [31:0] OSC_REG_OFS    = 32'h0000_0004;
   localparam logic [31:0] STATUS_REG_OFS = 32'h0000_0008;
   localparam logic [31:0] HALT_REG_OFS   = 32'h0000_000C;
   localparam int SEL_LSB       = 5;
   localparam int SEL_W         = 3;
   localparam int HS_KEEP_BIT   = 1;
   localparam int LS_KEEP_BIT   = 0;
   localparam int HS_EN_BIT     = 0;
   localparam int HALT_BIT      = 0;
   localparam int WAKE_BIT      = 1;
   localparam logic [2:0] SEL_RST     = 3'h0;
   localparam logic [2:0] SEL_SUB     = 3'h7;
   localparam logic [2:0] SEL_MAX_DIV = 3'h6;
   localparam logic       KEEP_RST    = 1'b0;
   localparam logic       HS_EN_RST   = 1'b1;
   localparam int DIV_W = 6;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;

   typedef enum logic [2:0]
   {
      MODE_FAST,
      MODE_SLOW,
      MODE_SLEEP,
      MODE_LOWCLK_STANDBY,
      MODE_DUALCLK_STANDBY,
      MODE_HICLK_STANDBY
   } scpm_mode_e;

   typedef struct packed
   {
      logic cpu_run;
      logic high_clock_en;
      logic sub_clock_en;
      logic slow_rc_osc_en;
      logic fast_rc_osc_en;
   } scpm_clk_en_s;
endpackage

// ---- src/scpm_clk_div.sv ----
// Divider chain of the high clock producing the one-cycle system clock tick.
`timescale 1ns/1ps
module scpm_clk_div
#(
   parameter int DIV_W = 6
)
(
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_ce,
   input  wire logic       i_run,
   input  wire logic [2:0] i_ratio_log2,
   output logic            o_tick
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] mask;
   logic             tick_q;
   wire  logic       wrap;

   // The mask keeps only the low ratio_log2 bits, so a count wraps at 2**ratio.
   assign mask = DIV_W'((7'h01 << i_ratio_log2) - 7'h01);
   assign wrap = ((cnt_q & mask) == mask);
   assign o_tick = tick_q;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end
      else if (i_ce)
      begin
         cnt_q  <= (i_run && !wrap) ? DIV_W'(cnt_q + 1'b1) : '0;
         tick_q <= i_run && wrap;
      end
   end
endmodule

// ---- src/scpm_ctrl.sv ----
// System clock selection and power operating mode controller with an AHB-Lite slave.
//
// Contract
// - The system clock comes from the high clock or the sub clock by the select field.
// - Divided high clocks from divide by 2 to divide by 64 are offered as system clock.
// - Full speed run uses the fast oscillator divided by 1 to 64 for codes 000 to 110.
// - Low speed run, code 111, runs the CPU from the sub clock of the slow oscillator.
// - Moving from high clock to sub clock stops the fast oscillator only when its enable bit is low.
// - In low speed run the high clock follows its oscillator enable bit.
// - The CPU runs only in the two run modes and is off in sleep and in all three standby modes.
// - Halt with both keep bits low enters sleep, stopping CPU and sub clock.
// - The slow oscillator keeps running in sleep for the watchdog.
// - Halt with high keep low and low keep high enters low-clock standby.
// - Halt with both keep bits high enters dual-clock standby with both oscillators.
// - Halt with high keep high and low keep low enters high-clock standby.
// - Code 000 is the undivided high clock, 001 to 110 divide by 2 to 64, 111 is sub.
`timescale 1ns/1ps
module scpm_ctrl
(
   input  wire logic                  i_clk,
   input  wire logic                  i_arst_n,
   input  wire logic                  i_ce,
   input  wire logic                  i_sub_clock_tick,
   input  wire logic                  i_halt,
   input  wire logic                  i_wake,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic [31:0]                hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic                       o_sys_tick,
   output scpm_pkg::scpm_clk_en_s     o_clk_en,
   output scpm_pkg::scpm_mode_e       o_mode
);
   logic [2:0]           sel_q;
   logic                 hs_keep_q;
   logic                 ls_keep_q;
   logic                 hs_en_q;
   logic                 halt_keep_hs_q;
   logic                 halt_keep_ls_q;
   logic                 sw_halt_q;
   logic                 sw_wake_q;
   scpm_pkg::scpm_mode_e mode_q;
   scpm_pkg::scpm_mode_e mode_d;
   scpm_pkg::scpm_clk_en_s en_d;
   scpm_pkg::scpm_clk_en_s en_q;
   logic [31:0]          hrdata_q;
   logic                 wr_pend_q;
   logic [31:0]          wr_addr_q;
   logic                 hs_tick;

   wire logic       bus_req  = hsel && hready && (htrans == scpm_pkg::HTRANS_NONSEQ ||
                                                  htrans == scpm_pkg::HTRANS_SEQ);
   wire logic       rd_req   = bus_req && !hwrite;
   wire logic       wr_req   = bus_req && hwrite;
   wire logic       wr_mode  = wr_pend_q && (wr_addr_q == scpm_pkg::MODE_REG_OFS);
   wire logic       wr_osc   = wr_pend_q && (wr_addr_q == scpm_pkg::OSC_REG_OFS);
   wire logic       wr_halt  = wr_pend_q && (wr_addr_q == scpm_pkg::HALT_REG_OFS);
   wire logic [2:0] wr_sel   = hwdata[scpm_pkg::SEL_LSB +: scpm_pkg::SEL_W];
   wire logic       halt_req = i_halt || sw_halt_q;
   wire logic       wake_req = i_wake || sw_wake_q;
   wire logic       running  = (mode_q == scpm_pkg::MODE_FAST) ||
                               (mode_q == scpm_pkg::MODE_SLOW);
   wire logic       use_sub  = (sel_q == scpm_pkg::SEL_SUB);
   wire logic [2:0] ratio    = use_sub ? 3'h0 : sel_q;
   wire logic [31:0] rd_mode = {24'h000000, sel_q, 3'h0, hs_keep_q, ls_keep_q};
   wire logic [31:0] rd_osc  = {31'h0, hs_en_q};
   wire logic [31:0] rd_stat = {24'h000000, en_q, mode_q};
   wire logic [31:0] rd_mux  =
      (haddr == scpm_pkg::MODE_REG_OFS)   ? rd_mode :
      (haddr == scpm_pkg::OSC_REG_OFS)    ? rd_osc  :
      (haddr == scpm_pkg::STATUS_REG_OFS) ? rd_stat : 32'h0000_0000;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign o_mode    = mode_q;
   assign o_clk_en  = en_q;
   // A standby mode has no CPU clock, so the tick is also gated by the cpu run flag.
   // The source follows the registered mode, so the tick never disagrees with o_mode.
   assign o_sys_tick = en_q.cpu_run &&
                       ((mode_q == scpm_pkg::MODE_SLOW) ? i_sub_clock_tick : hs_tick);

   scpm_clk_div #(.DIV_W(scpm_pkg::DIV_W)) u_div
   (
      .i_clk        (i_clk),
      .i_arst_n     (i_arst_n),
      .i_ce         (i_ce),
      .i_run        (en_q.high_clock_en),
      .i_ratio_log2 (ratio),
      .o_tick       (hs_tick)
   );

   // Write data arrives one cycle after the address phase, hence the pending write.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
         hrdata_q  <= 32'h0000_0000;
      end
      else if (i_ce)
      begin
         wr_pend_q <= wr_req;
         wr_addr_q <= wr_req ? haddr : wr_addr_q;
         hrdata_q  <= rd_req ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sel_q     <= scpm_pkg::SEL_RST;
         hs_keep_q <= scpm_pkg::KEEP_RST;
         ls_keep_q <= scpm_pkg::KEEP_RST;
         hs_en_q   <= scpm_pkg::HS_EN_RST;
      end
      else if (i_ce)
      begin
         if (wr_mode)
         begin
            sel_q     <= wr_sel;
            hs_keep_q <= hwdata[scpm_pkg::HS_KEEP_BIT];
            ls_keep_q <= hwdata[scpm_pkg::LS_KEEP_BIT];
         end
         if (wr_osc)
         begin
            hs_en_q <= hwdata[scpm_pkg::HS_EN_BIT];
         end
      end
   end

   // Software halt and wake requests are one-cycle strobes from the halt register.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sw_halt_q <= 1'b0;
         sw_wake_q <= 1'b0;
      end
      else if (i_ce)
      begin
         sw_halt_q <= wr_halt && hwdata[scpm_pkg::HALT_BIT];
         sw_wake_q <= wr_halt && hwdata[scpm_pkg::WAKE_BIT];
      end
   end

   // Keep bits are copied only at the halt so later writes cannot disturb standby.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         halt_keep_hs_q <= 1'b0;
         halt_keep_ls_q <= 1'b0;
      end
      else if (i_ce && running && halt_req)
      begin
         halt_keep_hs_q <= hs_keep_q;
         halt_keep_ls_q <= ls_keep_q;
      end
   end

   always_comb
   begin
      mode_d = mode_q;
      case (mode_q)
         scpm_pkg::MODE_FAST,
         scpm_pkg::MODE_SLOW:
         begin
            if (halt_req)
            begin
               case ({hs_keep_q, ls_keep_q})
                  2'b00:   mode_d = scpm_pkg::MODE_SLEEP;
                  2'b01:   mode_d = scpm_pkg::MODE_LOWCLK_STANDBY;
                  2'b11:   mode_d = scpm_pkg::MODE_DUALCLK_STANDBY;
                  default: mode_d = scpm_pkg::MODE_HICLK_STANDBY;
               endcase
            end
            else
            begin
               mode_d = use_sub ? scpm_pkg::MODE_SLOW : scpm_pkg::MODE_FAST;
            end
         end
         scpm_pkg::MODE_SLEEP,
         scpm_pkg::MODE_LOWCLK_STANDBY,
         scpm_pkg::MODE_DUALCLK_STANDBY,
         scpm_pkg::MODE_HICLK_STANDBY:
         begin
            if (wake_req)
            begin
               mode_d = use_sub ? scpm_pkg::MODE_SLOW : scpm_pkg::MODE_FAST;
            end
         end
         default: mode_d = scpm_pkg::MODE_FAST;
      endcase
   end

   always_comb
   begin
      en_d = '0;
      en_d.slow_rc_osc_en = 1'b1;
      case (mode_d)
         scpm_pkg::MODE_FAST:
         begin
            en_d.cpu_run        = 1'b1;
            en_d.fast_rc_osc_en = 1'b1;
            en_d.high_clock_en  = 1'b1;
            en_d.sub_clock_en   = 1'b1;
         end
         scpm_pkg::MODE_SLOW:
         begin
            en_d.cpu_run        = 1'b1;
            en_d.fast_rc_osc_en = hs_en_q;
            en_d.high_clock_en  = hs_en_q;
            en_d.sub_clock_en   = 1'b1;
         end
         scpm_pkg::MODE_SLEEP:
         begin
            en_d.sub_clock_en = 1'b0;
         end
         scpm_pkg::MODE_LOWCLK_STANDBY:
         begin
            en_d.sub_clock_en = 1'b1;
         end
         scpm_pkg::MODE_DUALCLK_STANDBY:
         begin
            en_d.fast_rc_osc_en = 1'b1;
            en_d.high_clock_en  = 1'b1;
            en_d.sub_clock_en   = 1'b1;
         end
         scpm_pkg::MODE_HICLK_STANDBY:
         begin
            en_d.fast_rc_osc_en = 1'b1;
            en_d.high_clock_en  = 1'b1;
         end
         default: en_d.cpu_run = 1'b1;
      endcase
   end

   // The new select takes effect one cycle after the write; is the software's wait.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mode_q <= scpm_pkg::MODE_FAST;
         en_q   <= 5'h1F;
      end
      else if (i_ce)
      begin
         mode_q <= mode_d;
         en_q   <= en_d;
      end
   end
endmodule

// ---- tb/scpm_ctrl_assertions.sv ----
// Concurrent checks on the ports of the clock and power mode controller.
`timescale 1ns/1ps
module scpm_ctrl_assertions
(
   input  wire logic                  i_clk,
   input  wire logic                  i_arst_n,
   input  wire logic                  i_ce,
   input  wire logic                  i_halt,
   input  wire logic                  i_sub_clock_tick,
   input  wire logic                  o_sys_tick,
   input  wire scpm_pkg::scpm_clk_en_s o_clk_en,
   input  wire scpm_pkg::scpm_mode_e   o_mode
);
   logic [2:0] m;
   logic [4:0] en;

   assign m  = o_mode;
   assign en = o_clk_en;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   fast_en_a: assert property (m == 3'h0 |-> en == 5'h1F) else $error("fast enables");
   slow_en_a: assert property (m == 3'h1 |-> en[4] && en[2] && en[3] == en[0])
      else $error("slow enables");
   sleep_en_a: assert property (m == 3'h2 |-> en == 5'h02) else $error("sleep enables");
   slow_rc_osc_on_a: assert property (en[1]) else $error("slow oscillator off");
   low_en_a: assert property (m == 3'h3 |-> en == 5'h06) else $error("low standby");
   dual_en_a: assert property (m == 3'h4 |-> en == 5'h0F) else $error("dual standby");
   high_en_a: assert property (m == 3'h5 |-> en == 5'h0B) else $error("high standby");
   cpu_mode_a: assert property (en[4] == (m <= 3'h1)) else $error("cpu run vs mode");
   halt_stop_a: assert property (i_ce && i_halt && en[4] |=> !en[4])
      else $error("halt ignored");
   tick_gate_a: assert property (!en[4] |-> !o_sys_tick) else $error("tick while off");
   sub_tick_a: assert property (i_ce && m == 3'h1 |-> o_sys_tick == i_sub_clock_tick)
      else $error("sub tick not passed");

   cover property (m == 3'h1 && o_sys_tick);
   cover property (m == 3'h4);
   cover property ($fell(en[4]));
endmodule

bind scpm_ctrl scpm_ctrl_assertions scpm_ctrl_assertions_i
(
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_halt(i_halt),
   .i_sub_clock_tick(i_sub_clock_tick), .o_sys_tick(o_sys_tick),
   .o_clk_en(o_clk_en), .o_mode(o_mode)
);

// ---- tb/sysclk_power_mode_ctrl_test.sv ----
// Self-checking bench of the system clock and power mode controller.
`timescale 1ns/1ps
module sysclk_power_mode_ctrl_test;
   logic                   i_clk, i_arst_n, i_sub_clock_tick, i_halt, i_wake, i_ce;
   logic                   hsel, hwrite, hreadyout, hresp, o_sys_tick;
   logic [1:0]             htrans;
   logic [31:0]            haddr, hwdata, hrdata, rd;
   scpm_pkg::scpm_clk_en_s o_clk_en;
   scpm_pkg::scpm_mode_e   o_mode;
   int                     n_fail, tests_run;

   scpm_ctrl scpm_ctrl_i
   (
      .i_clk, .i_arst_n, .i_ce, .i_sub_clock_tick, .i_halt, .i_wake,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .o_sys_tick, .o_clk_en, .o_mode
   );

   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic stop_test;
      if (n_fail == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   // Samples enables and mode mid-cycle, then returns on a rising edge.
   task automatic chk_st(input logic [7:0] want);
      @(negedge i_clk);
      chk({24'h0, o_clk_en, o_mode}, {24'h0, want});
      @(posedge i_clk);
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         n_fail++;
         stop_test();
      end
   endtask

   // One single AHB-Lite transfer; read data lands in rd.
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= scpm_pkg::HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic pulse(input logic h);
      i_halt <= h;
      i_wake <= !h;
      @(posedge i_clk);
      i_halt <= 1'b0;
      i_wake <= 1'b0;
   endtask

   task automatic t_reset;
      logic [31:0] want [4];
      want = '{32'h0, 32'h1, 32'hF8, 32'h0};
      chk_st(8'hF8);
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b0, 32'(4 * i + 4 * (i / 3)), 32'h0);
         chk(rd, want[i]);
      end
   endtask

   // Ticks are strictly periodic, so 128 cycles hold exactly 128 >> select of them.
   task automatic t_div;
      int cnt;
      for (int s = 0; s < 7; s++)
      begin
         bus(1'b1, scpm_pkg::MODE_REG_OFS, 32'(s) << scpm_pkg::SEL_LSB);
         repeat (70) @(posedge i_clk);
         cnt = 0;
         repeat (128)
         begin
            @(negedge i_clk);
            cnt += int'(o_sys_tick === 1'b1);
         end
         chk(32'(cnt), 32'h80 >> s);
         @(posedge i_clk);
      end
   endtask

   task automatic t_slow;
      bus(1'b1, scpm_pkg::OSC_REG_OFS, 32'h0);
      bus(1'b1, scpm_pkg::MODE_REG_OFS, 32'hE0);
      @(posedge i_clk);
      chk_st(8'hB1);
      i_sub_clock_tick <= 1'b1;
      @(negedge i_clk);
      chk(32'(o_sys_tick), 32'h1);
      @(posedge i_clk);
      i_sub_clock_tick <= 1'b0;
      bus(1'b1, scpm_pkg::OSC_REG_OFS, 32'h1);
      @(posedge i_clk);
      chk_st(8'hF9);
   endtask

   task automatic t_halt;
      logic [7:0] want [4];
      want = '{8'h12, 8'h33, 8'h5D, 8'h7C};
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b1, scpm_pkg::MODE_REG_OFS, 32'(k) | (k[0] ? 32'hE0 : 32'h0));
         @(posedge i_clk);
         chk_st(k[0] ? 8'hF9 : 8'hF8);
         if (k[1])
            pulse(1'b1);
         else
         begin
            bus(1'b1, scpm_pkg::HALT_REG_OFS, 32'h1);
            @(posedge i_clk);
         end
         chk_st(want[k]);
         pulse(1'b0);
         chk_st(k[0] ? 8'hF9 : 8'hF8);
      end
   endtask

   // A halt while the clock enable is low must leave the run mode untouched.
   task automatic t_freeze;
      i_ce <= 1'b0;
      pulse(1'b1);
      chk_st(8'hF9);
      i_ce <= 1'b1;
      @(posedge i_clk);
      chk_st(8'hF9);
   endtask

   initial
   begin
      n_fail = 0;
      i_ce = 1'b1;
      tests_run = 0;
      i_arst_n = 1'b0;
      i_sub_clock_tick = 1'b0;
      i_halt = 1'b0;
      i_wake = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      t_reset();
      t_div();
      t_slow();
      t_halt();
      t_freeze();
      stop_test();
   end
endmodule
